// file: sssc_top.sv
// SPI slave front end of a sixteen output low side switch
// How it works
// - Chip select rise applies shifted word
// - Excess daisy chain bits pass through
// - Each clock shifts status out, command in
// - Faulted outputs report one, healthy zero
// - Command one turns output on
// - Faults flagged only after qualification delay
// - Outputs switch 1 to 50 microseconds after
// - Sample on falling edge, drive on rising
// - Status word: any, overvoltage, zeros, outputs
// - Words shift most significant bit first
// - Deselected: ignore clock, output high impedance
`timescale 1ns/1ps
`include "sssc_consts.svh"
module sssc_top #(
    parameter int NOUT = `SSSC_OUT_COUNT,
    parameter int FAULT_CYC = `SSSC_FAULT_CYC,
    parameter int DLY_CYC = `SSSC_DLY_CYC
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe_n_out,
    input wire logic [NOUT-1:0] fault_raw_in,
    input wire logic ov_raw_in,
    output logic [NOUT-1:0] drive_out
);
    localparam int W = `SSSC_WORD_BITS;
    localparam int FCW = $clog2(FAULT_CYC + 1);
    localparam int DCW = $clog2(DLY_CYC + 1);

    // Two-flop synchronisers; first stage read only by second
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic sclk_q;
    logic cs_n_q;
    logic sdi_q;
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            // CS high, SCLK and SI low, as the pins idle; no false edge after reset
            sync_a <= 3'h4;
            sync_b <= 3'h4;
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
        end
        else
        begin
            sync_a <= {cs_n_in, sclk_in, sdi_in};
            sync_b <= sync_a;
            sclk_q <= sync_b[1];
            cs_n_q <= sync_b[2];
        end
    end
    assign sdi_q = sync_b[0];

    // Edge detection on synchronised pins
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    assign sclk_rise = sync_b[1] && !sclk_q;
    assign sclk_fall = !sync_b[1] && sclk_q;
    assign cs_fall = !sync_b[2] && cs_n_q;
    assign cs_rise = sync_b[2] && !cs_n_q;

    // Per-output fault qualification counters
    logic [NOUT-1:0] fault_q;
    logic ov_q;
    genvar g;
    generate
        for (g = 0; g < NOUT; g++)
        begin : g_qual
            logic [FCW-1:0] cnt;
            logic [FCW-1:0] next_cnt;
            logic next_flag;
            // Count persistent raw fault; a glitch restarts the wait
            always_comb
            begin
                next_cnt = cnt;
                next_flag = fault_q[g];
                if (!fault_raw_in[g])
                begin
                    next_cnt = '0;
                    next_flag = 1'b0;
                end
                else if (cnt == FCW'(FAULT_CYC))
                begin
                    next_flag = 1'b1;
                end
                else
                begin
                    next_cnt = cnt + 1'b1;
                end
            end
            always_ff @(posedge mclk_in)
            begin
                if (!rst_n_in)
                begin
                    cnt <= '0;
                    fault_q[g] <= 1'b0;
                end
                else
                begin
                    cnt <= next_cnt;
                    fault_q[g] <= next_flag;
                end
            end
        end
    endgenerate
    // Overvoltage comes already qualified from the supply monitor
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            ov_q <= 1'b0;
        end
        else
        begin
            ov_q <= ov_raw_in;
        end
    end

    // Frame engine: shift register, status load, latch on CS rise
    sssc_pkg::sssc_state_t state;
    sssc_pkg::sssc_state_t next_state;
    logic [W-1:0] shreg;
    logic [W-1:0] next_shreg;
    logic next_sdo;
    logic next_oe_n;
    logic push;
    logic next_push;
    sssc_pkg::sssc_frame_t frame;
    sssc_pkg::sssc_frame_t next_frame;
    logic fifo_ready;
    always_comb
    begin
        next_state = state;
        next_shreg = shreg;
        next_sdo = sdo_out;
        next_oe_n = sdo_oe_n_out;
        next_push = 1'b0;
        next_frame = frame;
        case (state)
            sssc_pkg::SSSC_IDLE:
            begin
                next_oe_n = 1'b1;
                if (cs_fall)
                begin
                    // Snapshot status, MSB shown first
                    next_shreg = {fault_q != '0 || ov_q, ov_q, 6'h00,
                                  fault_q};
                    next_sdo = next_shreg[W-1];
                    next_oe_n = 1'b0;
                    next_state = sssc_pkg::SSSC_SHIFT;
                end
            end
            sssc_pkg::SSSC_SHIFT:
            begin
                if (cs_rise)
                begin
                    next_oe_n = 1'b1;
                    next_frame.word = shreg;
                    next_state = sssc_pkg::SSSC_LATCH;
                end
                else if (sclk_fall)
                begin
                    // Sample command bit, oldest bit falls out the top
                    next_shreg = {shreg[W-2:0], sdi_q};
                end
                else if (sclk_rise)
                begin
                    next_sdo = shreg[W-1];
                end
            end
            sssc_pkg::SSSC_LATCH:
            begin
                // Wait for FIFO room rather than drop a command
                if (fifo_ready)
                begin
                    next_push = 1'b1;
                    next_state = sssc_pkg::SSSC_IDLE;
                end
            end
            default:
            begin
                next_state = sssc_pkg::SSSC_IDLE;
            end
        endcase
    end
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            state <= sssc_pkg::SSSC_IDLE;
            shreg <= '0;
            sdo_out <= 1'b0;
            sdo_oe_n_out <= 1'b1;
            push <= 1'b0;
            frame <= '0;
        end
        else
        begin
            state <= next_state;
            shreg <= next_shreg;
            sdo_out <= next_sdo;
            sdo_oe_n_out <= next_oe_n;
            push <= next_push;
            frame <= next_frame;
        end
    end

    // Command FIFO decouples frame capture from output timing
    logic [W-1:0] cmd_word;
    logic cmd_valid;
    logic cmd_take;
    sssc_fifo #(
        .WIDTH(W),
        .DEPTH(`SSSC_FIFO_DEPTH)
    ) u_fifo (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .wr_data_in(frame.word),
        .wr_valid_in(push),
        .wr_ready_out(fifo_ready),
        .rd_data_out(cmd_word),
        .rd_valid_out(cmd_valid),
        .rd_ready_in(cmd_take)
    );

    // Output delay stage: each command waits DLY_CYC then drives
    logic [DCW-1:0] dly;
    logic [DCW-1:0] next_dly;
    logic [NOUT-1:0] next_drive;
    always_comb
    begin
        next_dly = dly;
        next_drive = drive_out;
        cmd_take = 1'b0;
        if (cmd_valid)
        begin
            if (dly == DCW'(DLY_CYC))
            begin
                next_drive = cmd_word[NOUT-1:0];
                cmd_take = 1'b1;
                next_dly = '0;
            end
            else
            begin
                next_dly = dly + 1'b1;
            end
        end
    end
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            dly <= '0;
            drive_out <= '0;
        end
        else
        begin
            dly <= next_dly;
            drive_out <= next_drive;
        end
    end

    // Checks
    sequence s_frame_end;
        state == sssc_pkg::SSSC_SHIFT && cs_rise;
    endsequence
    property p_latch_push;
        @(posedge mclk_in) disable iff (!rst_n_in)
        s_frame_end ##1 fifo_ready |=> push;
    endproperty
    a_latch_push: assert property (p_latch_push) else $error("No push after CS rise");
    property p_oe_idle;
        @(posedge mclk_in) disable iff (!rst_n_in)
        state == sssc_pkg::SSSC_IDLE && !cs_fall |=> sdo_oe_n_out;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("SO driven while idle");
    property p_drive_only_delayed;
        @(posedge mclk_in) disable iff (!rst_n_in)
        $changed(drive_out) |-> $past(cmd_take);
    endproperty
    a_drive_only_delayed: assert property (p_drive_only_delayed) else $error("Drive changed early");
    property p_sdo_rise;
        @(posedge mclk_in) disable iff (!rst_n_in)
        state == sssc_pkg::SSSC_SHIFT && sclk_rise && !cs_rise |=> sdo_out == $past(shreg[W-1]);
    endproperty
    a_sdo_rise: assert property (p_sdo_rise) else $error("SO not MSB");
    property p_shift_in;
        @(posedge mclk_in) disable iff (!rst_n_in)
        state == sssc_pkg::SSSC_SHIFT && sclk_fall && !cs_rise |=> shreg[0] == $past(sdi_q);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("SI not sampled");
    property p_status_load;
        @(posedge mclk_in) disable iff (!rst_n_in)
        state == sssc_pkg::SSSC_IDLE && cs_fall |=> shreg[21:16] == 6'h00 && shreg[22] == $past(ov_q);
    endproperty
    a_status_load: assert property (p_status_load) else $error("Bad status word");
    property p_fault_clear;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !fault_raw_in[0] |=> !fault_q[0];
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("Fault without cause");
    property p_fault_wait;
        @(posedge mclk_in) disable iff (!rst_n_in)
        $rose(fault_q[0]) |-> $past(g_qual[0].cnt) == FCW'(FAULT_CYC);
    endproperty
    a_fault_wait: assert property (p_fault_wait) else $error("Fault set too early");
    property p_frame_word;
        @(posedge mclk_in) disable iff (!rst_n_in)
        s_frame_end |=> frame.word == $past(shreg);
    endproperty
    a_frame_word: assert property (p_frame_word) else $error("Wrong word kept");
endmodule

// file: sssc_consts.svh
// Timing counts, widths and bit positions for the serial switch front end
`ifndef SSSC_CONSTS_SVH
`define SSSC_CONSTS_SVH
`define SSSC_CLK_MHZ 100
`define SSSC_WORD_BITS 24
`define SSSC_OUT_COUNT 16
`define SSSC_BIT_ANY 23
`define SSSC_BIT_OV 22
`define SSSC_FAULT_MIN_US 100
`define SSSC_FAULT_MAX_US 450
`define SSSC_FAULT_CYC ((`SSSC_FAULT_MIN_US * `SSSC_CLK_MHZ + `SSSC_FAULT_MAX_US * `SSSC_CLK_MHZ) / 2)
`define SSSC_DLY_MIN_US 1
`define SSSC_DLY_CYC (`SSSC_DLY_MIN_US * `SSSC_CLK_MHZ)
`define SSSC_FIFO_DEPTH 16
`define SSSC_CMD_RESET 24'h000000
`endif

// file: sssc_pkg.sv
// Shared types for the serial switch front end
package sssc_pkg;
    // One captured command frame, carried through the FIFO
    typedef struct packed {
        logic [23:0] word;
    } sssc_frame_t;
    // Frame engine states
    typedef enum logic [2:0] {
        SSSC_IDLE = 3'b001,
        SSSC_SHIFT = 3'b010,
        SSSC_LATCH = 3'b100
    } sssc_state_t;
endpackage

// file: sssc_fifo.sv
// Parameterised valid/ready FIFO for captured command words
`timescale 1ns/1ps
module sssc_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    // Storage array
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW-1:0] next_wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [AW:0] next_count;
    logic do_wr;
    logic do_rd;

    // Handshake decisions and pointer updates
    always_comb
    begin
        do_wr = wr_valid_in && (count != (AW+1)'(DEPTH));
        do_rd = rd_ready_in && (count != '0);
        next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end

    // Registered state; full/empty flags honest from count
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            wr_ready_out <= 1'b0;
            rd_valid_out <= 1'b0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            wr_ready_out <= next_count != (AW+1)'(DEPTH);
            rd_valid_out <= next_count != '0;
        end
    end

    // Data path, no reset needed on storage
    always_ff @(posedge mclk_in)
    begin
        if (do_wr)
        begin
            mem[wr_ptr] <= wr_data_in;
        end
    end
    assign rd_data_out = mem[rd_ptr];
endmodule

// file: sssc_spi_master.sv
// SPI master model that stands in for the microcontroller
`timescale 1ns/1ps
module sssc_spi_master #(
    // Half period of the bench link clock
    parameter real HALF = 62.5
) (
    output logic sclk_out,
    output logic cs_n_out,
    output logic sdi_out,
    output logic oe_ok_out,
    input wire logic sdo_in,
    input wire logic sdo_oe_n_in
);
    // Released lines sit at their pull levels; clock stands still
    initial
    begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out = 1'b0;
        oe_ok_out = 1'b1;
    end
    // One frame of n bits from the top of tx; 24 per chained device
    task automatic xfer(input logic [47:0] tx, input int n, output logic [47:0] rx);
        rx = '0;
        oe_ok_out = 1'b1;
        cs_n_out = 1'b0;
        #200;
        for (int i = 0; i < n; i++)
        begin
            sclk_out = 1'b1;
            sdi_out = tx[47-i];
            #HALF;
            // Sample on the fall; SO must be driven here
            rx = {rx[46:0], sdo_in};
            oe_ok_out = oe_ok_out & ~sdo_oe_n_in;
            sclk_out = 1'b0;
            #HALF;
        end
        #100;
        cs_n_out = 1'b1;
        sdi_out = 1'b0;
    endtask
    // Wiggle clock and data while deselected
    task automatic noise();
        for (int i = 0; i < 8; i++)
        begin
            sclk_out = ~sclk_out;
            sdi_out = ~sdi_out;
            #HALF;
        end
    endtask
endmodule

// file: test_spi_serial_switch_control.sv
// Self-checking bench for the serial switch front end
`timescale 1ns/1ps
module test_spi_serial_switch_control;
    localparam int FCYC = 20; // Short fault qualification
    localparam int DCYC = 5; // Short switching delay
    localparam int DCYC_B = 1000; // Long delay so commands queue in the buffer
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic sclk, cs_n, sdi, sdo, sdo_oe_n, oe_ok;
    logic ov_raw = 1'b0;
    logic [15:0] fault_raw = '0;
    logic [15:0] drive;
    logic [15:0] drive_b;
    logic sel_b = 1'b0; // Routes the shared bus to the second device
    logic cs_a_n, cs_b_n, sdo_b, sdo_oe_n_b, miso, miso_oe_n;
    logic [47:0] rx;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    sssc_top #(.NOUT(16), .FAULT_CYC(FCYC), .DLY_CYC(DCYC)) dut (.mclk_in(mclk),
        .rst_n_in(rst_n), .sclk_in(sclk), .cs_n_in(cs_a_n), .sdi_in(sdi), .sdo_out(sdo),
        .sdo_oe_n_out(sdo_oe_n), .fault_raw_in(fault_raw), .ov_raw_in(ov_raw),
        .drive_out(drive));
    // Parallel neighbour with a long delay; its buffer is filled through its pins
    sssc_top #(.NOUT(16), .FAULT_CYC(FCYC), .DLY_CYC(DCYC_B)) dut_b (.mclk_in(mclk),
        .rst_n_in(rst_n), .sclk_in(sclk), .cs_n_in(cs_b_n), .sdi_in(sdi), .sdo_out(sdo_b),
        .sdo_oe_n_out(sdo_oe_n_b), .fault_raw_in(fault_raw), .ov_raw_in(ov_raw),
        .drive_out(drive_b));
    // Own select per device; clock, data in and MISO are shared
    assign cs_a_n = cs_n | sel_b;
    assign cs_b_n = cs_n | ~sel_b;
    assign miso = sel_b ? sdo_b : sdo;
    assign miso_oe_n = sel_b ? sdo_oe_n_b : sdo_oe_n;
    sssc_spi_master m (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi), .oe_ok_out(oe_ok),
        .sdo_in(miso), .sdo_oe_n_in(miso_oe_n));
    // System clock
    always #5 mclk = ~mclk;
    // Hang guard, far above the expected run length
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            n_errors++;
            close_out();
        end
    end
    task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // One frame, then the hold, the delay and the applied drive
    task automatic frame(input logic [47:0] tx, input int n, input logic [47:0] exp_rx,
        input logic [15:0] exp_drv);
        logic [15:0] old;
        old = drive;
        m.xfer(tx, n, rx);
        chk("status", exp_rx, rx);
        chk("so_enabled", 48'h1, 48'(oe_ok));
        chk("held", 48'(old), 48'(drive));
        repeat (DCYC) @(negedge mclk);
        chk("early", 48'(old), 48'(drive));
        for (int i = 0; i < 40 && drive !== exp_drv; i++)
            @(negedge mclk);
        chk("drive", 48'(exp_drv), 48'(drive));
        chk("so_off", 48'h1, 48'(sdo_oe_n));
        // Spacing past the qualification time
        repeat (2 * FCYC) @(negedge mclk);
    endtask
    task automatic t_plain();
        frame({24'h00a5c3, 24'h0}, 24, 48'h0, 16'ha5c3);
        frame({24'h005a3c, 24'h0}, 24, 48'h0, 16'h5a3c);
        $display("test plain done");
    endtask
    task automatic t_fault();
        fault_raw = 16'h8001;
        // Captured before qualification, so still clean
        frame({24'h00ffff, 24'h0}, 24, 48'h0, 16'hffff);
        frame({24'h000000, 24'h0}, 24, 48'h808001, 16'h0000);
        fault_raw = 16'h0000;
        ov_raw = 1'b1;
        repeat (3) @(negedge mclk);
        frame({24'h000001, 24'h0}, 24, 48'hc00000, 16'h0001);
        ov_raw = 1'b0;
        $display("test fault done");
    endtask
    task automatic t_chain();
        // First word falls through to SO; last word is kept
        frame({24'h00c3c3, 24'h007e81}, 48, 48'h00c3c3, 16'h7e81);
        $display("test chain done");
    endtask
    task automatic t_quiet();
        m.noise();
        repeat (20) @(negedge mclk);
        chk("quiet_drive", 48'h7e81, 48'(drive));
        chk("quiet_so", 48'h1, 48'(sdo_oe_n));
        chk("par_drive", 48'h0, 48'(drive_b));
        chk("par_so", 48'h1, 48'(sdo_oe_n_b));
        $display("test quiet done");
    endtask
    // Wait for the next queued command to reach the outputs, in order
    task automatic pop(input logic [15:0] exp);
        for (int i = 0; i < 1100 && drive_b !== exp; i++)
            @(negedge mclk);
        chk("pop", 48'(exp), 48'(drive_b));
    endtask
    // Three quick frames to the slow neighbour queue up and drain in order
    task automatic t_burst();
        logic [47:0] r;
        sel_b = 1'b1;
        m.xfer({24'h001111, 24'h0}, 24, r);
        chk("burst_status", 48'h0, r);
        repeat (4) @(negedge mclk);
        m.xfer({24'h002222, 24'h0}, 24, r);
        repeat (4) @(negedge mclk);
        m.xfer({24'h003333, 24'h0}, 24, r);
        chk("queued", 48'h0, 48'(drive_b));
        pop(16'h1111);
        pop(16'h2222);
        pop(16'h3333);
        chk("par_other", 48'h7e81, 48'(drive));
        sel_b = 1'b0;
        $display("test burst done");
    endtask
    // Main sequence
    initial
    begin
        repeat (6) @(negedge mclk);
        chk("rst_drive", 48'h0, 48'(drive));
        chk("rst_so", 48'h1, 48'(sdo_oe_n));
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        t_plain();
        t_fault();
        t_chain();
        t_quiet();
        t_burst();
        close_out();
    end
endmodule
